// [rtl/smr_pkg.sv]
// Package: constants and carriers for the serial mode readout port
package smr_pkg;

  localparam int MODE_W      = 4;
  localparam int CTRL_W      = 36;
  localparam int PART_W      = 24;
  localparam int STAT_W      = 28;
  localparam int COUNT_W     = 20;
  localparam int FLAG_W      = 4;
  localparam int DIV_W       = 16;
  localparam int OUT_W       = 7;

  // Mode codes
  localparam logic [3:0] MODE_FULL = 4'h1;
  localparam logic [3:0] MODE_PART = 4'h2;
  localparam logic [3:0] MODE_READ = 4'h3;

  // Control word field positions (first received bit is bit 0)
  localparam int DIV_LSB     = 0;
  localparam int OUT_LSB     = 16;
  localparam int RUN_POS     = 23;

  // Bits expected after the frame strobe rises
  localparam logic [5:0] FULL_BITS = 6'h24;
  localparam logic [5:0] PART_BITS = 6'h18;

  localparam logic [35:0] CTRL_RESET = 36'h0;

  typedef struct packed {
    logic [15:0] divider_word;
    logic [6:0]  port_out_bits;
    logic        meas_run;
    logic [11:0] other_bits;
  } smr_ctrl_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ = 4'b0100,
    ST_SKIP = 4'b1000
  } smr_state_e;

endpackage

// [rtl/smr_port.sv]
// Serial mode, control write and status readout port
`timescale 1ns/1ps
// Overview of operation
// - 28-bit shift register carries port states, count and phase flags out.
// - Status snapshot is captured when readout mode becomes selected.
// - Port bit zero from pin zero, port bit one from pin one.
// - Count bits load from the 20-bit counter, MSB to MSB.
// - Four phase-error flags load from the unlock detector.
// - Only full write, partial write and readout modes exist; others invalid.
// - Mode fixed at strobe rising edge and held for the frame.
// - Mode 0001 loads all 36 control bits.
// - Mode 0010 loads divider, output bits and run bit; 12 unchanged.
// - Mode 0011 drives status on the serial output.
// - Invalid modes transfer nothing and leave control unchanged.
// - Readout presents port bit zero at strobe rise, shifts on falling clock.
// - Strobe fall ending readout forces serial output high.
// - After readout, output goes low on pin zero change or count done.
// - Measurement completion takes precedence over pin zero change.
// - Run bit 0 clears counter; run bit 1 starts and drives output high.
// - While run bit is 1, pin zero changes do not pull output low.
// - Live flags set on phase-error pulse, cleared at strobe rise.
module smr_port
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                frame_strobe,
  input  wire logic                shift_tick,
  input  wire logic                serial_in,
  input  wire logic                port_in_zero,
  input  wire logic                port_in_one,
  input  wire logic [19:0]         meas_count_bits,
  input  wire logic                meas_done,
  input  wire logic [3:0]          phase_err_pulse,
  output logic                     serial_out,
  output smr_pkg::smr_ctrl_s       ctrl,
  output logic                     meas_clear,
  output logic                     meas_start,
  output logic [3:0]               phase_err_flags
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins are asynchronous to clk; two stages before any use
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] sync_c;
  always_ff @(posedge clk)
  begin
    sync_a <= {frame_strobe, shift_tick, serial_in, port_in_zero, port_in_one};
    sync_b <= sync_a;
    sync_c <= sync_b;
  end

  logic strobe_s;
  logic tick_s;
  logic din_s;
  logic pin0_s;
  logic pin1_s;
  assign strobe_s = sync_b[4];
  assign tick_s   = sync_b[3];
  assign din_s    = sync_b[2];
  assign pin0_s   = sync_b[1];
  assign pin1_s   = sync_b[0];

  logic strobe_rise;
  logic strobe_fall;
  logic tick_rise;
  logic tick_fall;
  logic pin0_change;
  assign strobe_rise = strobe_s & ~sync_c[4];
  assign strobe_fall = ~strobe_s & sync_c[4];
  assign tick_rise   = tick_s & ~sync_c[3];
  assign tick_fall   = ~tick_s & sync_c[3];
  assign pin0_change = pin0_s ^ sync_c[1];

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  smr_pkg::smr_state_e state;
  logic [3:0]  mode_shift;
  logic [3:0]  mode;
  logic [35:0] rx_word;
  logic [5:0]  rx_count;
  logic [27:0] tx_shift;
  logic [3:0]  live_flags;

  // Mode bits arrive highest first while the strobe is low
  always_ff @(posedge clk)
  begin
    if (reset)
      mode_shift <= 4'h0;
    else if (!strobe_s && tick_rise)
      mode_shift <= {mode_shift[2:0], din_s};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= smr_pkg::ST_IDLE;
      mode  <= 4'h0;
    end
    else if (strobe_rise)
    begin
      mode <= mode_shift;
      unique case (mode_shift)
        smr_pkg::MODE_FULL,
        smr_pkg::MODE_PART: state <= smr_pkg::ST_WRITE;
        smr_pkg::MODE_READ: state <= smr_pkg::ST_READ;
        default:            state <= smr_pkg::ST_SKIP;
      endcase
    end
    else if (strobe_fall)
      state <= smr_pkg::ST_IDLE;
  end

  // Control bits shift in from the top so bit 0 lands lowest
  always_ff @(posedge clk)
  begin
    if (reset || strobe_rise)
    begin
      rx_word  <= 36'h0;
      rx_count <= 6'h00;
    end
    else if (state == smr_pkg::ST_WRITE && tick_rise)
    begin
      rx_word <= {din_s, rx_word[35:1]};
      if (rx_count != 6'h3F)
        rx_count <= rx_count + 6'h01;
    end
  end

  // Partial frame leaves data in the top 24 bits; realign it
  logic [35:0] part_word;
  assign part_word = {12'h000, rx_word[35:12]};

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic apply_full;
  logic apply_part;
  assign apply_full = strobe_fall && state == smr_pkg::ST_WRITE
                      && mode == smr_pkg::MODE_FULL
                      && rx_count == smr_pkg::FULL_BITS;
  assign apply_part = strobe_fall && state == smr_pkg::ST_WRITE
                      && mode == smr_pkg::MODE_PART
                      && rx_count == smr_pkg::PART_BITS;

  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl <= smr_pkg::smr_ctrl_s'(smr_pkg::CTRL_RESET);
    else if (apply_full)
    begin
      ctrl.divider_word  <= rx_word[15:0];
      ctrl.port_out_bits <= rx_word[22:16];
      ctrl.meas_run      <= rx_word[smr_pkg::RUN_POS];
      ctrl.other_bits    <= rx_word[35:24];
    end
    else if (apply_part)
    begin
      ctrl.divider_word  <= part_word[15:0];
      ctrl.port_out_bits <= part_word[22:16];
      ctrl.meas_run      <= part_word[smr_pkg::RUN_POS];
    end
  end

  // Struct packs divider at the top, so both modes update field-wise

  logic new_run;
  logic run_write;
  assign run_write = apply_full | apply_part;
  // Run bit sits at a different rx_word position in each write mode
  assign new_run   = (mode == smr_pkg::MODE_FULL)
                     ? rx_word[smr_pkg::RUN_POS]
                     : part_word[smr_pkg::RUN_POS];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meas_clear <= 1'b0;
      meas_start <= 1'b0;
    end
    else
    begin
      meas_clear <= run_write && !new_run;
      meas_start <= run_write && new_run;
    end
  end

  // ----------------------------------------------------------------
  // Phase-error flags
  // ----------------------------------------------------------------
  // Set wins over the clear at strobe rise so no pulse is lost
  genvar g;
  generate
    for (g = 0; g < smr_pkg::FLAG_W; g++)
    begin : g_flag
      always_ff @(posedge clk)
      begin
        if (reset)
          live_flags[g] <= 1'b0;
        else if (phase_err_pulse[g])
          live_flags[g] <= 1'b1;
        else if (strobe_rise)
          live_flags[g] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (reset)
      phase_err_flags <= 4'h0;
    else
      phase_err_flags <= live_flags;
  end

  // ----------------------------------------------------------------
  // Status shift and serial output
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      tx_shift <= 28'h0;
    else if (strobe_rise && mode_shift == smr_pkg::MODE_READ)
      tx_shift <= {pin0_s,
                   pin1_s,
                   meas_count_bits,
                   2'h0,
                   live_flags[3], live_flags[2],
                   live_flags[1], live_flags[0]};
    else if (state == smr_pkg::ST_READ && tick_fall)
      tx_shift <= {tx_shift[26:0], 1'b1};
  end
  // Two zero bits before the flags put flag zero on the 27th falling tick

  logic watch;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      serial_out <= 1'b1;
      watch      <= 1'b0;
    end
    else if (strobe_rise && mode_shift == smr_pkg::MODE_READ)
    begin
      serial_out <= pin0_s;
      watch      <= 1'b0;
    end
    else if (state == smr_pkg::ST_READ && strobe_fall)
    begin
      serial_out <= 1'b1;
      watch      <= 1'b1;
    end
    else if (state == smr_pkg::ST_READ)
    begin
      if (tick_fall)
        serial_out <= tx_shift[26];
    end
    else if (run_write && new_run)
      serial_out <= 1'b1;
    else if (watch && meas_done)
      serial_out <= 1'b0;
    else if (watch && pin0_change && !ctrl.meas_run)
      serial_out <= 1'b0;
  end

endmodule

// [test/smr_port_asserts.sv]
// Concurrent checks on the serial mode readout port
`timescale 1ns/1ps
module smr_port_asserts
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               frame_strobe,
  input wire logic               meas_done,
  input wire logic [3:0]         phase_err_pulse,
  input wire logic               serial_out,
  input wire smr_pkg::smr_ctrl_s ctrl,
  input wire logic               meas_clear,
  input wire logic               meas_start,
  input wire logic [3:0]         phase_err_flags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_rst;
    $fell(reset) |-> serial_out && ctrl == '0 && phase_err_flags == '0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state");
  property p_excl;
    !(meas_clear && meas_start);
  endproperty
  a_excl: assert property (p_excl)
    else $error("clear with start");
  property p_start;
    meas_start |=> !meas_start;
  endproperty
  a_start: assert property (p_start)
    else $error("start too long");
  property p_clr;
    meas_clear |=> !meas_clear;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear too long");
  property p_hold;
    frame_strobe [*4] |-> $stable(ctrl);
  endproperty
  a_hold: assert property (p_hold)
    else $error("ctrl moved in frame");
  property p_set;
    phase_err_pulse[3] |-> ##[1:2] phase_err_flags[3];
  endproperty
  a_set: assert property (p_set)
    else $error("flag not set");
  property p_cause;
    $rose(phase_err_flags[1]) |->
      $past(phase_err_pulse[1]) || $past(phase_err_pulse[1], 2);
  endproperty
  a_cause: assert property (p_cause)
    else $error("flag without pulse");
  property p_done;
    !frame_strobe [*6] ##1 meas_done |-> ##[1:4] !serial_out;
  endproperty
  a_done: assert property (p_done)
    else $error("done not shown");
endmodule
bind smr_port smr_port_asserts u_smr_port_asserts
(
  .clk(clk), .reset(reset), .frame_strobe(frame_strobe),
  .meas_done(meas_done), .phase_err_pulse(phase_err_pulse),
  .serial_out(serial_out), .ctrl(ctrl), .meas_clear(meas_clear),
  .meas_start(meas_start), .phase_err_flags(phase_err_flags)
);

// [test/smr_ctl_model.sv]
// Controller model driving the three-wire frame pins
`timescale 1ns/1ps
module smr_ctl_model
(
  input  wire logic clk,
  input  wire logic serial_out,
  output logic      frame_strobe,
  output logic      shift_tick,
  output logic      serial_in
);
  initial
  begin
    frame_strobe = 1'b0;
    shift_tick = 1'b0;
    serial_in = 1'b0;
  end
  task automatic tick(input logic b);
    serial_in <= b;
    repeat (2) @(posedge clk);
    shift_tick <= 1'b1;
    repeat (4) @(posedge clk);
    shift_tick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Tick stands low between frames; released data shows its inverse
  task automatic frame(input logic [3:0] m, input logic [35:0] d,
                       input int n, output logic [27:0] st);
    st = '0;
    for (int i = 3; i >= 0; i--) tick(m[i]);
    serial_in <= ~serial_in;
    frame_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    if (m == smr_pkg::MODE_READ)
      for (int i = 0; i < 28; i++)
      begin
        if (i > 0)
        begin
          shift_tick <= 1'b0;
          repeat (4) @(posedge clk);
        end
        shift_tick <= 1'b1;
        repeat (4) @(posedge clk);
        st = {st[26:0], serial_out};
      end
    else
      for (int i = 0; i < n; i++) tick(d[i]);
    serial_in <= ~serial_in;
    frame_strobe <= 1'b0;
    repeat (8) @(posedge clk);
    shift_tick <= 1'b0;
  endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the serial mode readout port
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pz = 1'b0;
  logic p1 = 1'b0;
  logic [19:0] cnt = '0;
  logic done = 1'b0;
  logic [3:0] pulse = '0;
  logic fs, tk, si, so, mclr, mst;
  logic [3:0] flags;
  smr_pkg::smr_ctrl_s ctrl;
  int fails = 0;
  int check_count = 0;
  int starts = 0;
  int clears = 0;
  logic [27:0] st;
  logic [35:0] w;
  initial forever #20 clk = ~clk;
  // Pulses last one cycle, so count them as they pass
  always @(posedge clk)
  begin
    if (mst === 1'b1)
      starts <= starts + 1;
    if (mclr === 1'b1)
      clears <= clears + 1;
  end
  smr_port u_smr_port (.clk(clk), .reset(reset), .frame_strobe(fs),
    .shift_tick(tk), .serial_in(si), .port_in_zero(pz),
    .port_in_one(p1), .meas_count_bits(cnt), .meas_done(done),
    .phase_err_pulse(pulse), .serial_out(so), .ctrl(ctrl),
    .meas_clear(mclr), .meas_start(mst), .phase_err_flags(flags));
  smr_ctl_model u_smr_ctl_model (.clk(clk), .serial_out(so),
    .frame_strobe(fs), .shift_tick(tk), .serial_in(si));
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [35:0] map(input logic [35:0] d);
    return {d[15:0], d[22:16], d[23], d[35:24]};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    wt(16);
    reset <= 1'b0;
    wt(4);
    chk(ctrl, '0);
    w = 36'h9A58C3D71;
    u_smr_ctl_model.frame(smr_pkg::MODE_FULL, w, 36, st);
    chk(ctrl, map(w));
    chk(starts, 1);
    w = {w[35:24], 24'h3C5AA1};
    u_smr_ctl_model.frame(smr_pkg::MODE_PART, w, 24, st);
    chk(ctrl, map(w));
    chk(clears, 1);
    u_smr_ctl_model.frame(smr_pkg::MODE_PART, ~w, 23, st);
    chk(ctrl, map(w));
    chk(starts, 1);
    for (int m = 0; m < 16; m++)
      if (m == 0 || m > 3)
        u_smr_ctl_model.frame(4'(m), ~w, 36, st);
    chk(ctrl, map(w));
    p1 <= 1'b1;
    wt(4);
    u_smr_ctl_model.frame(smr_pkg::MODE_READ, '0, 0, st);
    chk(st, {1'b0, 1'b1, 20'h00000, 2'h0, 4'h0});
    pz <= 1'b1;
    p1 <= 1'b0;
    cnt <= 20'hA5C3F;
    pulse <= 4'hA;
    wt(1);
    pulse <= 4'h0;
    wt(4);
    chk(flags, 4'hA);
    // Count moves mid-frame to prove the snapshot was taken
    fork
      u_smr_ctl_model.frame(smr_pkg::MODE_READ, '0, 0, st);
      begin
        wt(60);
        cnt <= 20'h0;
      end
    join
    chk(st, {1'b1, 1'b0, 20'hA5C3F, 2'h0, 4'hA});
    chk(so, 1'b1);
    chk(flags, 4'h0);
    pz <= 1'b0;
    wt(8);
    chk(so, 1'b0);
    u_smr_ctl_model.frame(smr_pkg::MODE_PART, 36'h8012FF, 24, st);
    chk(so, 1'b1);
    chk(starts, 2);
    pz <= 1'b1;
    wt(8);
    chk(so, 1'b1);
    done <= 1'b1;
    pz <= 1'b0;
    wt(1);
    done <= 1'b0;
    wt(8);
    chk(so, 1'b0);
    complete_run();
  end
  initial
  begin
    wt(20000);
    fails++;
    complete_run();
  end
endmodule
